/* File: core/fmc_map.svh */
// offsets, field positions, reset values and timing counts of the fan monitor
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

`define FMC_SLAVE_ADDR    7'h2E
`define FMC_OFS_EXTCFG    8'h7C
`define FMC_OFS_PINFN     8'h7D
`define FMC_OFS_FANDUTY   8'h30
`define FMC_OFS_FANCTL    8'h31
`define FMC_OFS_MAXDUTY   8'h32
`define FMC_OFS_LFFREQ    8'h33
`define FMC_OFS_TEMPOFS   8'h34
`define FMC_OFS_THLIM     8'h35
`define FMC_OFS_GPOUT     8'h36
`define FMC_OFS_STATUS2   8'h37

`define FMC_BIT_RANGE     0
`define FMC_BIT_LOWFREQ   1
`define FMC_BIT_GPDIR     2
`define FMC_BIT_GPPOL     3
`define FMC_BIT_PINSTAT   5
`define FMC_BIT_MONEN     6
`define FMC_BIT_TOFAIL    7

`define FMC_RST_EXTCFG    8'h01
`define FMC_RST_PINFN     8'h00
`define FMC_RST_THLIM     8'hA4
`define FMC_RST_MAXDUTY   8'hFF
`define FMC_RST_LFFREQ    8'h0A
`define FMC_RST_ZERO      8'h00

`define FMC_LF_MIN_HZ     8'h0A
`define FMC_LF_MAX_HZ     8'h64
`define FMC_CLK_HZ        64'd50000000
`define FMC_HF_HZ         64'd22500
`define FMC_PWM_STEPS     64'd256
`define FMC_HF_INC  32'(((64'h1 << 32) * `FMC_PWM_STEPS * `FMC_HF_HZ) / `FMC_CLK_HZ)
`define FMC_LF_UNIT 32'(((64'h1 << 32) * `FMC_PWM_STEPS) / `FMC_CLK_HZ)
`define FMC_FAILSAFE_MS   4600
`define FMC_FAILSAFE_CYC  (`FMC_FAILSAFE_MS * 50000)

`endif

/* File: core/fmc_pkg.sv */
// types of the fan monitor configuration block
package fmc_pkg;

	typedef enum logic [1:0] {
		FMC_PIN_TACH  = 2'h0,
		FMC_PIN_ALERT = 2'h1,
		FMC_PIN_THERMAL_LIMIT_PIN = 2'h2,
		FMC_PIN_GPIO  = 2'h3
	} fmc_pin_fn_t;

	typedef enum logic [3:0] {
		FMC_ST_IDLE = 4'h0,
		FMC_ST_ADDR = 4'h1,
		FMC_ST_ACKA = 4'h3,
		FMC_ST_PTR  = 4'h2,
		FMC_ST_ACKP = 4'h6,
		FMC_ST_DATA = 4'h7,
		FMC_ST_ACKD = 4'h5,
		FMC_ST_READ = 4'h4,
		FMC_ST_RACK = 4'hC
	} fmc_link_st_t;

endpackage : fmc_pkg

/* File: core/fmc_smbus_link.sv */
// two-wire serial slave running on the link clock
`timescale 1ns/1ps
`include "fmc_map.svh"
module fmc_smbus_link (
	input  wire logic       linkClk,
	input  wire logic       nrst,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	output logic            wrTgl,
	output logic [7:0]      wrByte,
	output logic            wrIsData,
	output logic            doneTgl,
	output logic            rdReqTgl,
	input  wire logic       rdAckTgl,
	input  wire logic [7:0] rdData
);
	logic [2:0]               syncA_r, syncB_r;
	logic                     sclP_r, sdaP_r, ackP_r;
	fmc_pkg::fmc_link_st_t    st_r, st_nxt;
	logic [2:0]               bitCnt_r, bitCnt_nxt;
	logic [7:0]               rx_r, rx_nxt, tx_r, tx_nxt, hold_r, hold_nxt;
	logic [7:0]               wrByte_r, wrByte_nxt;
	logic                     done_r, done_nxt, rw_r, rw_nxt, adr_r, adr_nxt;
	logic                     wrTgl_r, wrTgl_nxt, isData_r, isData_nxt;
	logic                     doneTgl_r, doneTgl_nxt, rdTgl_r, rdTgl_nxt;
	logic                     sclS, sdaS, sclRise, sclFall, startC, stopC, rxSt;

	default clocking cbl @(posedge linkClk);
	endclocking
	default disable iff (!nrst);

	assign sclS    = syncB_r[0];
	assign sdaS    = syncB_r[1];
	assign sclRise = sclS & ~sclP_r;
	assign sclFall = ~sclS & sclP_r;
	assign startC  = sclS & sclP_r & sdaP_r & ~sdaS;
	assign stopC   = sclS & sclP_r & ~sdaP_r & sdaS;
	assign rxSt    = (st_r == fmc_pkg::FMC_ST_ADDR) |
	                 (st_r == fmc_pkg::FMC_ST_PTR) | (st_r == fmc_pkg::FMC_ST_DATA);

	always_comb
	begin
		st_nxt = st_r;
		bitCnt_nxt = bitCnt_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		hold_nxt = hold_r;
		done_nxt = done_r;
		rw_nxt = rw_r;
		adr_nxt = adr_r;
		wrTgl_nxt = wrTgl_r;
		wrByte_nxt = wrByte_r;
		isData_nxt = isData_r;
		doneTgl_nxt = doneTgl_r;
		rdTgl_nxt = rdTgl_r;
		if (syncB_r[2] != ackP_r)
			hold_nxt = rdData;
		if (startC)
		begin
			st_nxt = fmc_pkg::FMC_ST_ADDR;
			bitCnt_nxt = 3'h0;
			done_nxt = 1'b0;
		end
		else if (stopC)
		begin
			if (adr_r)
				doneTgl_nxt = ~doneTgl_r;
			adr_nxt = 1'b0;
			st_nxt = fmc_pkg::FMC_ST_IDLE;
		end
		else
		begin
			if (sclRise && rxSt)
			begin
				rx_nxt = {rx_r[6:0], sdaS};
				bitCnt_nxt = bitCnt_r + 3'h1;
				if (bitCnt_r == 3'h7)
					done_nxt = 1'b1;
			end
			if (sclFall)
			begin
				case (st_r)
				fmc_pkg::FMC_ST_ADDR:
					if (done_r)
					begin
						done_nxt = 1'b0;
						if (rx_r[7:1] == `FMC_SLAVE_ADDR)
						begin
							st_nxt = fmc_pkg::FMC_ST_ACKA;
							rw_nxt = rx_r[0];
							adr_nxt = 1'b1;
							if (rx_r[0])
								rdTgl_nxt = ~rdTgl_r;
						end
						else
							st_nxt = fmc_pkg::FMC_ST_IDLE;
					end
				fmc_pkg::FMC_ST_ACKA:
				begin
					bitCnt_nxt = 3'h0;
					tx_nxt = hold_r;
					st_nxt = rw_r ? fmc_pkg::FMC_ST_READ : fmc_pkg::FMC_ST_PTR;
				end
				fmc_pkg::FMC_ST_PTR, fmc_pkg::FMC_ST_DATA:
					if (done_r)
					begin
						done_nxt = 1'b0;
						wrTgl_nxt = ~wrTgl_r;
						wrByte_nxt = rx_r;
						isData_nxt = (st_r == fmc_pkg::FMC_ST_DATA);
						st_nxt = (st_r == fmc_pkg::FMC_ST_DATA) ?
						         fmc_pkg::FMC_ST_ACKD : fmc_pkg::FMC_ST_ACKP;
					end
				fmc_pkg::FMC_ST_ACKP, fmc_pkg::FMC_ST_ACKD:
					st_nxt = fmc_pkg::FMC_ST_DATA;
				fmc_pkg::FMC_ST_READ:
				begin
					tx_nxt = {tx_r[6:0], 1'b1};
					bitCnt_nxt = bitCnt_r + 3'h1;
					if (bitCnt_r == 3'h7)
						st_nxt = fmc_pkg::FMC_ST_RACK;
				end
				fmc_pkg::FMC_ST_RACK:
				begin
					tx_nxt = hold_r;
					bitCnt_nxt = 3'h0;
					// ninth bit as held before the clock fell
					st_nxt = sdaP_r ? fmc_pkg::FMC_ST_IDLE : fmc_pkg::FMC_ST_READ;
				end
				default:
					st_nxt = fmc_pkg::FMC_ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge linkClk or negedge nrst)
	begin
		if (!nrst)
		begin
			// idle bus levels, no false edge after reset
			syncA_r <= 3'h3;
			syncB_r <= 3'h3;
			sclP_r <= 1'b1;
			sdaP_r <= 1'b1;
			ackP_r <= 1'b0;
			st_r <= fmc_pkg::FMC_ST_IDLE;
			bitCnt_r <= 3'h0;
			rx_r <= 8'h00;
			tx_r <= 8'hFF;
			hold_r <= 8'h00;
			done_r <= 1'b0;
			rw_r <= 1'b0;
			adr_r <= 1'b0;
			wrTgl_r <= 1'b0;
			wrByte_r <= 8'h00;
			isData_r <= 1'b0;
			doneTgl_r <= 1'b0;
			rdTgl_r <= 1'b0;
		end
		else
		begin
			syncA_r <= {rdAckTgl, sdaIn, sclIn};
			syncB_r <= syncA_r;
			sclP_r <= syncB_r[0];
			sdaP_r <= syncB_r[1];
			ackP_r <= syncB_r[2];
			st_r <= st_nxt;
			bitCnt_r <= bitCnt_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			hold_r <= hold_nxt;
			done_r <= done_nxt;
			rw_r <= rw_nxt;
			adr_r <= adr_nxt;
			wrTgl_r <= wrTgl_nxt;
			wrByte_r <= wrByte_nxt;
			isData_r <= isData_nxt;
			doneTgl_r <= doneTgl_nxt;
			rdTgl_r <= rdTgl_nxt;
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe = (st_r == fmc_pkg::FMC_ST_ACKA) |
	               (st_r == fmc_pkg::FMC_ST_ACKP) |
	               (st_r == fmc_pkg::FMC_ST_ACKD) |
	               ((st_r == fmc_pkg::FMC_ST_READ) & ~tx_r[7]);
	assign wrTgl = wrTgl_r;
	assign wrByte = wrByte_r;
	assign wrIsData = isData_r;
	assign doneTgl = doneTgl_r;
	assign rdReqTgl = rdTgl_r;

	property p_addr_match;
		(st_r == fmc_pkg::FMC_ST_ACKA && $past(st_r) == fmc_pkg::FMC_ST_ADDR)
		|-> rx_r[7:1] == `FMC_SLAVE_ADDR;
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("acknowledged a foreign address");

	property p_ack_drive;
		st_r == fmc_pkg::FMC_ST_ACKA |-> sdaOe && !sdaOut;
	endproperty
	a_ack_drive: assert property (p_ack_drive)
		else $error("address acknowledge not driven low");

endmodule : fmc_smbus_link

/* File: core/fmc_config_failsafe.sv */
// fan monitor configuration, start-up and fail-safe control
//
// Overview of operation
// - bit1 clear: fan drive at 22.5 kHz
// - bit1 set: fan drive 10 to 100 Hz
// - bit0 picks extended or legacy temperature range
// - bit2 sets general pin direction
// - bit3 sets general pin polarity
// - pin function register routes shared pin
// - shared pin status in status bit5
// - monitoring starts on supply rise or transaction
// - fans off after power-up until programmed
// - over thermal limit forces full speed
// - no address 4.6 s after supply: full
// - no supply: no timeout; write restores normal
// - answer only slave address 0x2E
// - automatic duty capped at programmable maximum
// - offset register spans -64 to +63.5 degrees, half steps
// - all access over two-wire serial bus
`timescale 1ns/1ps
`include "fmc_map.svh"
module fmc_config_failsafe #(
	parameter int unsigned FAILSAFE_CYCLES = `FMC_FAILSAFE_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       linkClk,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic       coreSupplyIn,
	input  wire logic [7:0] tempMeas,
	input  wire logic [7:0] autoDuty,
	input  wire logic       alertReq,
	input  wire logic       mfIn,
	output logic            mfOut,
	output logic            mfOe,
	output logic            fourthTachLevel,
	output logic            processorHotSeen,
	output logic [2:0]      fanPwm,
	output logic            monitorEn,
	output logic            failsafeActive
);
	logic                  wrTgl, wrIsData, doneTgl, rdReqTgl;
	logic [7:0]            wrByte;
	logic [4:0]            asyncIn, syncPrev_r;
	wire  [4:0]            syncB;
	logic                  wrEvt, doneEvt, rdEvt, supRise, mfS;
	logic [7:0]            ptr_r, ptr_nxt, extCfg_r, extCfg_nxt;
	logic [7:0]            pinFn_r, pinFn_nxt, duty_r, duty_nxt;
	logic [7:0]            fanCtl_r, fanCtl_nxt, maxDuty_r, maxDuty_nxt;
	logic [7:0]            lfFreq_r, lfFreq_nxt, tempOfs_r, tempOfs_nxt;
	logic [7:0]            thLim_r, thLim_nxt, gpOut_r, gpOut_nxt;
	logic [7:0]            rdSnap_r, rdSnap_nxt, rdMux, status2;
	logic                  rdAck_r, rdAck_nxt, hostProg_r, hostProg_nxt;
	logic                  monEn_r, monEn_nxt, armed_r, armed_nxt;
	logic                  addressed_r, addressed_nxt, toFail_r, toFail_nxt;
	logic                  setFail;
	logic [31:0]           failCnt_r, failCnt_nxt;
	logic [31:0]           phase_r, phase_nxt, phaseInc;
	logic [32:0]           phaseSum;
	logic [7:0]            pwmCnt_r, pwmCnt_nxt, lfClamp, dutyEff;
	logic [2:0]            fanPwm_r, fanPwm_nxt;
	logic [9:0]            tempAdj, limAdj, ofsWhole;
	logic                  overTemp, fanFull;
	fmc_pkg::fmc_pin_fn_t  pinMode;
	logic                  mfOut_r, mfOut_nxt, mfOe_r, mfOe_nxt;
	logic                  pinStat_r, pinStat_nxt, tach_r, tach_nxt;
	logic                  hot_r, hot_nxt;

	default clocking cbs @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// serial slave on the link clock
	fmc_smbus_link u_link (
		.linkClk  (linkClk),
		.nrst     (nrst),
		.sclIn    (sclIn),
		.sdaIn    (sdaIn),
		.sdaOut   (sdaOut),
		.sdaOe    (sdaOe),
		.wrTgl    (wrTgl),
		.wrByte   (wrByte),
		.wrIsData (wrIsData),
		.doneTgl  (doneTgl),
		.rdReqTgl (rdReqTgl),
		.rdAckTgl (rdAck_r),
		.rdData   (rdSnap_r)
	);

	assign asyncIn = {mfIn, coreSupplyIn, rdReqTgl, doneTgl, wrTgl};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_sync
			logic stA_r, stB_r;
			always_ff @(posedge sys_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					stA_r <= 1'b0;
					stB_r <= 1'b0;
				end
				else
				begin
					stA_r <= asyncIn[gi];
					stB_r <= stA_r;
				end
			end
			assign syncB[gi] = stB_r;
		end
	endgenerate

	assign wrEvt   = syncB[0] ^ syncPrev_r[0];
	assign doneEvt = syncB[1] ^ syncPrev_r[1];
	assign rdEvt   = syncB[2] ^ syncPrev_r[2];
	assign supRise = syncB[3] & ~syncPrev_r[3];
	assign mfS     = syncB[4];

	// shared pin status and upper flags
	always_comb
	begin
		status2 = 8'h00;
		status2[`FMC_BIT_PINSTAT] = pinStat_r;
		status2[`FMC_BIT_MONEN] = monEn_r;
		status2[`FMC_BIT_TOFAIL] = toFail_r;
		case (ptr_r)
		`FMC_OFS_EXTCFG:  rdMux = extCfg_r;
		`FMC_OFS_PINFN:   rdMux = pinFn_r;
		`FMC_OFS_FANDUTY: rdMux = duty_r;
		`FMC_OFS_FANCTL:  rdMux = fanCtl_r;
		`FMC_OFS_MAXDUTY: rdMux = maxDuty_r;
		`FMC_OFS_LFFREQ:  rdMux = lfFreq_r;
		`FMC_OFS_TEMPOFS: rdMux = tempOfs_r;
		`FMC_OFS_THLIM:   rdMux = thLim_r;
		`FMC_OFS_GPOUT:   rdMux = gpOut_r;
		`FMC_OFS_STATUS2: rdMux = status2;
		default:          rdMux = 8'h00;
		endcase
	end

	// register file, pointer and read snapshot
	always_comb
	begin
		ptr_nxt = ptr_r;
		extCfg_nxt = extCfg_r;
		pinFn_nxt = pinFn_r;
		duty_nxt = duty_r;
		fanCtl_nxt = fanCtl_r;
		maxDuty_nxt = maxDuty_r;
		lfFreq_nxt = lfFreq_r;
		tempOfs_nxt = tempOfs_r;
		thLim_nxt = thLim_r;
		gpOut_nxt = gpOut_r;
		hostProg_nxt = hostProg_r;
		rdSnap_nxt = rdSnap_r;
		rdAck_nxt = rdAck_r;
		if (wrEvt && !wrIsData)
			ptr_nxt = wrByte;
		if (wrEvt && wrIsData)
		begin
			// a data write to a defined register other than status (0x37) counts as programming
			hostProg_nxt = 1'b1;
			case (ptr_r)
			`FMC_OFS_EXTCFG:  extCfg_nxt = wrByte;
			`FMC_OFS_PINFN:   pinFn_nxt = wrByte;
			`FMC_OFS_FANDUTY: duty_nxt = wrByte;
			`FMC_OFS_FANCTL:  fanCtl_nxt = wrByte;
			`FMC_OFS_MAXDUTY: maxDuty_nxt = wrByte;
			`FMC_OFS_LFFREQ:  lfFreq_nxt = wrByte;
			`FMC_OFS_TEMPOFS: tempOfs_nxt = wrByte;
			`FMC_OFS_THLIM:   thLim_nxt = wrByte;
			`FMC_OFS_GPOUT:   gpOut_nxt = wrByte;
			default:          hostProg_nxt = hostProg_r;
			endcase
		end
		if (rdEvt)
		begin
			rdSnap_nxt = rdMux;
			rdAck_nxt = ~rdAck_r;
		end
	end

	// start-up and timeout fail-safe
	always_comb
	begin
		monEn_nxt = monEn_r;
		armed_nxt = armed_r;
		addressed_nxt = addressed_r;
		failCnt_nxt = failCnt_r;
		setFail = 1'b0;
		if (armed_r)
		begin
			failCnt_nxt = failCnt_r + 32'h1;
			if (failCnt_r == 32'(FAILSAFE_CYCLES - 1))
			begin
				setFail = 1'b1;
				armed_nxt = 1'b0;
			end
		end
		if (supRise)
		begin
			monEn_nxt = 1'b1;
			if (!addressed_r)
			begin
				armed_nxt = 1'b1;
				failCnt_nxt = 32'h0;
			end
		end
		if (doneEvt)
		begin
			monEn_nxt = 1'b1;
			addressed_nxt = 1'b1;
			armed_nxt = 1'b0;
			setFail = 1'b0;
		end
		// host write clears fail-safe, set wins
		toFail_nxt = setFail | (toFail_r & ~wrEvt);
	end

	// offset in half degrees to whole
	assign ofsWhole = {{3{tempOfs_r[7]}}, tempOfs_r[7:1]};
	// range select, bit0 set is offset-64
	assign tempAdj = (extCfg_r[`FMC_BIT_RANGE] ? {2'h0, tempMeas} :
	                 {{2{tempMeas[7]}}, tempMeas}) + ofsWhole;
	assign limAdj = extCfg_r[`FMC_BIT_RANGE] ? {2'h0, thLim_r} :
	                {{2{thLim_r[7]}}, thLim_r};
	assign overTemp = $signed(tempAdj) > $signed(limAdj);
	assign fanFull = overTemp | toFail_r;

	// fan drive generator
	always_comb
	begin
		if (lfFreq_r < `FMC_LF_MIN_HZ)
			lfClamp = `FMC_LF_MIN_HZ;
		else if (lfFreq_r > `FMC_LF_MAX_HZ)
			lfClamp = `FMC_LF_MAX_HZ;
		else
			lfClamp = lfFreq_r;
		if (extCfg_r[`FMC_BIT_LOWFREQ])
			phaseInc = {24'h0, lfClamp} * `FMC_LF_UNIT;
		else
			phaseInc = `FMC_HF_INC;
		phaseSum = {1'b0, phase_r} + {1'b0, phaseInc};
		phase_nxt = phaseSum[31:0];
		pwmCnt_nxt = pwmCnt_r + {7'h0, phaseSum[32]};
		if (fanCtl_r[0])
			dutyEff = (autoDuty > maxDuty_r) ? maxDuty_r : autoDuty;
		else
			dutyEff = duty_r;
		// off until programmed, full on fail-safe
		fanPwm_nxt = {3{fanFull | (hostProg_r & (pwmCnt_r < dutyEff))}};
	end

	// shared multifunction pin
	assign pinMode = fmc_pkg::fmc_pin_fn_t'(pinFn_r[1:0]);
	always_comb
	begin
		mfOut_nxt = 1'b1;
		mfOe_nxt = 1'b0;
		tach_nxt = 1'b0;
		hot_nxt = 1'b0;
		pinStat_nxt = 1'b0;
		case (pinMode)
		fmc_pkg::FMC_PIN_TACH:
		begin
			tach_nxt = mfS;
			pinStat_nxt = mfS;
		end
		fmc_pkg::FMC_PIN_THERMAL_LIMIT_PIN:
		begin
			mfOut_nxt = 1'b0;
			mfOe_nxt = overTemp;
			hot_nxt = ~mfS;
			pinStat_nxt = ~mfS;
		end
		fmc_pkg::FMC_PIN_ALERT:
		begin
			mfOut_nxt = 1'b0;
			mfOe_nxt = alertReq;
			pinStat_nxt = alertReq;
		end
		fmc_pkg::FMC_PIN_GPIO:
		begin
			mfOe_nxt = extCfg_r[`FMC_BIT_GPDIR];
			mfOut_nxt = gpOut_r[0] ~^ extCfg_r[`FMC_BIT_GPPOL];
			pinStat_nxt = mfS ~^ extCfg_r[`FMC_BIT_GPPOL];
		end
		default:
			mfOe_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			syncPrev_r <= 5'h00;
			ptr_r <= `FMC_RST_ZERO;
			extCfg_r <= `FMC_RST_EXTCFG;
			pinFn_r <= `FMC_RST_PINFN;
			duty_r <= `FMC_RST_ZERO;
			fanCtl_r <= `FMC_RST_ZERO;
			maxDuty_r <= `FMC_RST_MAXDUTY;
			lfFreq_r <= `FMC_RST_LFFREQ;
			tempOfs_r <= `FMC_RST_ZERO;
			thLim_r <= `FMC_RST_THLIM;
			gpOut_r <= `FMC_RST_ZERO;
			hostProg_r <= 1'b0;
			rdSnap_r <= `FMC_RST_ZERO;
			rdAck_r <= 1'b0;
			monEn_r <= 1'b0;
			armed_r <= 1'b0;
			addressed_r <= 1'b0;
			failCnt_r <= 32'h0;
			toFail_r <= 1'b0;
			phase_r <= 32'h0;
			pwmCnt_r <= 8'h00;
			fanPwm_r <= 3'h0;
			mfOut_r <= 1'b1;
			mfOe_r <= 1'b0;
			tach_r <= 1'b0;
			hot_r <= 1'b0;
			pinStat_r <= 1'b0;
		end
		else
		begin
			syncPrev_r <= syncB;
			ptr_r <= ptr_nxt;
			extCfg_r <= extCfg_nxt;
			pinFn_r <= pinFn_nxt;
			duty_r <= duty_nxt;
			fanCtl_r <= fanCtl_nxt;
			maxDuty_r <= maxDuty_nxt;
			lfFreq_r <= lfFreq_nxt;
			tempOfs_r <= tempOfs_nxt;
			thLim_r <= thLim_nxt;
			gpOut_r <= gpOut_nxt;
			hostProg_r <= hostProg_nxt;
			rdSnap_r <= rdSnap_nxt;
			rdAck_r <= rdAck_nxt;
			monEn_r <= monEn_nxt;
			armed_r <= armed_nxt;
			addressed_r <= addressed_nxt;
			failCnt_r <= failCnt_nxt;
			toFail_r <= toFail_nxt;
			phase_r <= phase_nxt;
			pwmCnt_r <= pwmCnt_nxt;
			fanPwm_r <= fanPwm_nxt;
			mfOut_r <= mfOut_nxt;
			mfOe_r <= mfOe_nxt;
			tach_r <= tach_nxt;
			hot_r <= hot_nxt;
			pinStat_r <= pinStat_nxt;
		end
	end

	assign fanPwm = fanPwm_r;
	assign mfOut = mfOut_r;
	assign mfOe = mfOe_r;
	assign fourthTachLevel = tach_r;
	assign processorHotSeen = hot_r;
	assign monitorEn = monEn_r;
	assign failsafeActive = toFail_r;

	sequence s_supRise;
		!syncB[3] ##1 syncB[3];
	endsequence
	sequence s_expire;
		armed_r && failCnt_r == 32'(FAILSAFE_CYCLES - 1) && !doneEvt;
	endsequence

	property p_hf_rate;
		!extCfg_r[`FMC_BIT_LOWFREQ] |-> phaseInc == `FMC_HF_INC;
	endproperty
	a_hf_rate: assert property (p_hf_rate)
		else $error("high frequency step wrong");
	property p_lf_rate;
		extCfg_r[`FMC_BIT_LOWFREQ] |-> phaseInc >= 32'h0000_0A * `FMC_LF_UNIT
			&& phaseInc <= 32'h0000_64 * `FMC_LF_UNIT;
	endproperty
	a_lf_rate: assert property (p_lf_rate)
		else $error("low frequency step out of range");
	property p_range;
		(extCfg_r[`FMC_BIT_RANGE] && tempOfs_r == 8'h00)
		|-> tempAdj == {2'h0, tempMeas};
	endproperty
	a_range: assert property (p_range)
		else $error("extended range not offset coded");
	property p_alert_pin;
		(pinMode == fmc_pkg::FMC_PIN_ALERT && alertReq && !wrEvt)
		|=> mfOe && !mfOut;
	endproperty
	a_alert_pin: assert property (p_alert_pin)
		else $error("alert not driven on shared pin");
	property p_gpio_stat;
		(pinMode == fmc_pkg::FMC_PIN_GPIO && !wrEvt)
		|=> pinStat_r == ($past(mfS) ~^ extCfg_r[`FMC_BIT_GPPOL]);
	endproperty
	a_gpio_stat: assert property (p_gpio_stat)
		else $error("pin status bit wrong");
	property p_mon_start;
		s_supRise |=> monEn_r;
	endproperty
	a_mon_start: assert property (p_mon_start)
		else $error("monitoring not started on supply rise");
	property p_fans_off;
		(!hostProg_r && !fanFull) |=> fanPwm == 3'h0;
	endproperty
	a_fans_off: assert property (p_fans_off)
		else $error("fans driven before programming");
	property p_over_full;
		overTemp |=> fanPwm == 3'h7;
	endproperty
	a_over_full: assert property (p_over_full)
		else $error("over temperature without full drive");
	property p_timeout;
		s_expire |=> toFail_r ##1 fanPwm == 3'h7;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout fail-safe missing");
	property p_write_clears;
		(wrEvt && !setFail) |=> !toFail_r;
	endproperty
	a_write_clears: assert property (p_write_clears)
		else $error("host write left fail-safe on");
	property p_max_duty;
		fanCtl_r[0] |-> dutyEff <= maxDuty_r;
	endproperty
	a_max_duty: assert property (p_max_duty)
		else $error("automatic duty above maximum");
	property p_done;
		doneEvt |=> !armed_r && monEn_r ##1 !armed_r;
	endproperty
	a_done: assert property (p_done)
		else $error("transaction did not cancel timeout");

endmodule : fmc_config_failsafe

/* File: test/fmc_smbus_host.sv */
// serial bus host model driving the two-wire pins
`timescale 1ns/1ps
module fmc_smbus_host (
	input  wire logic clk,
	input  wire logic sdaLine,
	output logic      sclOut,
	output logic      sdaDrv
);
	initial
	begin
		sclOut = 1'b1;
		sdaDrv = 1'b1;
	end
	task tick;
		repeat (25) @(posedge clk);
	endtask : tick
	task bit_io(input logic b, output logic s);
		sdaDrv <= b;
		tick();
		sclOut <= 1'b1;
		tick();
		s = sdaLine;
		sclOut <= 1'b0;
	endtask : bit_io
	// released ninth bit carries ack
	task byte_io(input logic [7:0] d, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'b1, a);
	endtask : byte_io
	// address first, then pointer and data, or one read byte
	task xfer(input logic [6:0] a, input logic rd, input logic [7:0] p,
		input logic [7:0] d, input logic wd, output logic [7:0] q,
		output logic ack);
		logic [7:0] junk;
		logic       k;
		q = 8'h00;
		sdaDrv <= 1'b1;
		tick();
		sclOut <= 1'b1;
		tick();
		sdaDrv <= 1'b0;
		tick();
		sclOut <= 1'b0;
		byte_io({a, rd}, junk, ack);
		if (!ack && rd)
			byte_io(8'hFF, q, k);
		if (!ack && !rd)
			byte_io(p, junk, k);
		if (!ack && !rd && wd)
			byte_io(d, junk, k);
		sdaDrv <= 1'b0;
		tick();
		sclOut <= 1'b1;
		tick();
		sdaDrv <= 1'b1;
		tick();
	endtask : xfer
endmodule : fmc_smbus_host

/* File: test/fmc_config_failsafe_tb.sv */
// self-checking bench of the fan monitor configuration block
`timescale 1ns/1ps
`include "fmc_map.svh"
module fmc_config_failsafe_tb;
	localparam int unsigned FS = 200;
	logic        sys_clk = 1'b0;
	logic        linkClk = 1'b0;
	logic        nrst = 1'b0;
	logic        coreSupplyIn = 1'b0;
	logic        alertReq = 1'b0;
	logic        mfIn = 1'b0;
	logic [7:0]  tempMeas = 8'h00;
	logic [7:0]  autoDuty = 8'h00;
	logic [15:0] seed = 16'h298E;
	logic [7:0]  regm [256];
	logic [7:0]  q;
	logic        ack, e, sclIn, sdaDrv, sdaOe, mfOut, mfOe, tach, hot;
	logic        monitorEn, failsafeActive, sdaOut;
	logic [2:0]  fanPwm;
	int          errors = 0;
	int          total_checks = 0;
	int          n, tn, hiC, tgC, d;
	wire         sdaLine = sdaDrv & (~sdaOe | sdaOut);
	always #10 sys_clk = ~sys_clk;
	initial
	begin
		#7;
		forever #15 linkClk = ~linkClk;
	end
	fmc_config_failsafe #(.FAILSAFE_CYCLES(FS)) dut_u (
		.sys_clk(sys_clk), .nrst(nrst), .linkClk(linkClk), .sclIn(sclIn),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.coreSupplyIn(coreSupplyIn), .tempMeas(tempMeas),
		.autoDuty(autoDuty), .alertReq(alertReq), .mfIn(mfIn),
		.mfOut(mfOut), .mfOe(mfOe), .fourthTachLevel(tach),
		.processorHotSeen(hot), .fanPwm(fanPwm), .monitorEn(monitorEn),
		.failsafeActive(failsafeActive));
	fmc_smbus_host host_u (.clk(sys_clk), .sdaLine(sdaLine),
		.sclOut(sclIn), .sdaDrv(sdaDrv));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : cyc
	task endt;
		tn++;
		$display("test %0d finished", tn);
	endtask : endt
	// high cycles and edges of the fan drive over two fast periods
	task meas(output int hi, output int tg);
		logic p0;
		hi = 0;
		tg = 0;
		p0 = fanPwm[0];
		repeat (4444)
		begin
			@(negedge sys_clk);
			hi += fanPwm[0];
			tg += (fanPwm[0] != p0);
			p0 = fanPwm[0];
		end
	endtask : meas
	task wr(input logic [7:0] p, input logic [7:0] d);
		host_u.xfer(`FMC_SLAVE_ADDR, 1'b0, p, d, 1'b1, q, ack);
		check(8'(ack), 8'h00);
		regm[p] = d;
	endtask : wr
	task rd(input logic [7:0] p, output logic [7:0] r);
		host_u.xfer(`FMC_SLAVE_ADDR, 1'b0, p, 8'h00, 1'b0, r, ack);
		host_u.xfer(`FMC_SLAVE_ADDR, 1'b1, 8'h00, 8'h00, 1'b0, r, ack);
		check(8'(ack), 8'h00);
	endtask : rd
	initial
	begin
		#1800000;
		errors++;
		final_report();
	end
	initial
	begin
		tn = 0;
		regm[8'h7C] = 8'h01;
		regm[8'h7D] = 8'h00;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		cyc(4);
		check(8'(fanPwm), 8'h00);
		check(8'(monitorEn), 8'h00);
		@(posedge sys_clk);
		coreSupplyIn <= 1'b1;
		n = 0;
		while (failsafeActive !== 1'b1 && n < 2 * FS)
		begin
			@(negedge sys_clk);
			n++;
		end
		check(8'(n >= FS && n <= FS + 10), 8'h01);
		if (n == 2 * FS)
			final_report();
		cyc(2);
		check(8'(fanPwm), 8'h07);
		check(8'(monitorEn), 8'h01);
		endt();
		wr(8'h7C, 8'h01);
		cyc(8);
		check(8'(failsafeActive), 8'h00);
		check(8'(fanPwm), 8'h00);
		host_u.xfer(7'h2F, 1'b0, 8'h7C, 8'h00, 1'b1, q, ack);
		check(8'(ack), 8'h01);
		rd(8'h7D, q);
		check(q, regm[8'h7D]);
		endt();
		seed = lfsr(seed);
		@(posedge sys_clk);
		tempMeas <= 8'hA5 + seed[7:0] % 8'h5B;
		autoDuty <= seed[15:8];
		cyc(2);
		check(8'(fanPwm), 8'h07);
		@(posedge sys_clk);
		tempMeas <= 8'h40;
		cyc(2);
		check(8'(fanPwm), 8'h00);
		endt();
		for (int m = 0; m < 4; m++)
		begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			mfIn <= seed[0];
			alertReq <= seed[1];
			wr(8'h7D, 8'(m));
			rd(8'h37, q);
			cyc(1);
			e = m == 1 ? seed[1] : (m == 0 ? seed[0] : !seed[0]);
			check(8'(q[5]), 8'(e));
			check(8'(tach), 8'(m == 0 && seed[0]));
			check(8'(hot), 8'(m == 2 && !seed[0]));
		end
		endt();
		for (int p = 0; p < 2; p++)
		begin
			wr(8'h7C, 8'h05 | 8'(p << 3));
			wr(8'h36, 8'h01);
			cyc(2);
			check(8'(mfOe), 8'h01);
			check(8'(mfOut), 8'(p));
			rd(8'h7C, q);
			check(q, regm[8'h7C]);
		end
		endt();
		wr(8'h7C, 8'h00);
		// limit given again in twos complement
		wr(8'h35, 8'h64);
		@(posedge sys_clk);
		tempMeas <= 8'hC8;
		cyc(2);
		check(8'(fanPwm), 8'h00);
		@(posedge sys_clk);
		tempMeas <= 8'h65;
		cyc(2);
		check(8'(fanPwm), 8'h07);
		wr(8'h34, 8'hF8);
		cyc(2);
		check(8'(fanPwm), 8'h00);
		endt();
		seed = lfsr(seed);
		@(posedge sys_clk);
		autoDuty <= seed[7:0] | 8'h70;
		wr(8'h32, 8'h60);
		wr(8'h31, 8'h01);
		meas(hiC, tgC);
		d = hiC * 256 / 4444 - int'(autoDuty > 8'h60 ? 8'h60 : autoDuty);
		check(8'(d >= -3 && d <= 3), 8'h01);
		wr(8'h31, 8'h00);
		wr(8'h30, 8'h80);
		meas(hiC, tgC);
		check(8'(tgC >= 3 && tgC <= 5), 8'h01);
		wr(8'h33, 8'h64);
		wr(8'h7C, 8'h02);
		meas(hiC, tgC);
		check(8'(tgC <= 1), 8'h01);
		endt();
		@(posedge sys_clk);
		nrst <= 1'b0;
		coreSupplyIn <= 1'b0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		cyc(2 * FS);
		check(8'(failsafeActive), 8'h00);
		check(8'(monitorEn), 8'h00);
		wr(8'h30, 8'h00);
		cyc(8);
		check(8'(monitorEn), 8'h01);
		check(8'(fanPwm), 8'h00);
		endt();
		final_report();
	end
endmodule : fmc_config_failsafe_tb
